// *** src/fob_defs.svh ***
`ifndef FOB_DEFS_SVH
`define FOB_DEFS_SVH

// Register byte offsets
`define FOB_REG_CTRL 12'h000
`define FOB_REG_STATUS 12'h004
`define FOB_REG_IRQ_STATUS 12'h008
`define FOB_REG_IRQ_MASK 12'h00C
`define FOB_REG_SB_CTRL 12'h010

// Control register fields
`define FOB_CTRL_OE_LSB 0
`define FOB_CTRL_SLEW_SEL 8
`define FOB_CTRL_SLEW_SW 9
`define FOB_CTRL_RESET 32'h000000FF

// Status register fields
`define FOB_ST_ENABLE_LSB 0
`define FOB_ST_SB_MODE 8
`define FOB_ST_STARTED 9
`define FOB_ST_POWER_DOWN 10
`define FOB_ST_LOST 11
`define FOB_ST_SLEW 12
`define FOB_ST_ADDR_LSB 16

// Interrupt bits
`define FOB_IRQ_LOST 0
`define FOB_IRQ_FOUND 1
`define FOB_IRQ_LOAD 2
`define FOB_IRQ_SLEEP 3
`define FOB_IRQ_BITS 4

// Loss detection window in ns
`define FOB_LOSS_WINDOW_NS 1000

`endif

// *** src/fob_pkg.sv ***
`default_nettype none
package fob_pkg;
    typedef enum logic [1:0] {
        FOB_WAIT_GOOD = 2'b00,
        FOB_RUN = 2'b01,
        FOB_SLEEP = 2'b11
    } fob_power_e;

    typedef enum logic [1:0] {
        FOB_TRI_LOW = 2'b00,
        FOB_TRI_MID = 2'b01,
        FOB_TRI_HIGH = 2'b10
    } fob_tri_e;
endpackage : fob_pkg
`default_nettype wire

// *** src/fob_sync.sv ***
`timescale 1ns/1ns
`default_nettype none
module fob_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Pins
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] stable,
    output logic [WIDTH-1:0] rise,
    output logic [WIDTH-1:0] fall
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
        end else begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // Each bit moves on its own once its stages two and three agree
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            stable <= '0;
        end else begin
            stable <= ((stage2 ~^ stage3) & stage3) | ((stage2 ^ stage3) & stable);
        end
    end

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_edge
            assign rise[i] = (stage2[i] == stage3[i]) && stage3[i] && !stable[i];
            assign fall[i] = (stage2[i] == stage3[i]) && !stage3[i] && stable[i];
        end
    endgenerate
endmodule : fob_sync
`default_nettype wire

// *** src/fob_loss_detect.sv ***
`timescale 1ns/1ns
`include "fob_defs.svh"
`default_nettype none
module fob_loss_detect #(
    parameter int WINDOW_CYCLES = 100
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Reference clock edges from the synchroniser
    input wire logic ref_rise,
    // Result
    output logic lost
);
    logic [15:0] idle_count;

    // Counts cycles since last reference edge; lost until first edge
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            idle_count <= 16'h0000;
            lost <= 1'b1;
        end else if (ref_rise) begin
            idle_count <= 16'h0000;
            lost <= 1'b0;
        end else if (idle_count >= 16'(WINDOW_CYCLES - 1)) begin
            lost <= 1'b1;
        end else begin
            idle_count <= idle_count + 16'h0001;
        end
    end

    a_loss_after_idle: assert property (@(posedge clk) disable iff (!reset_n)
        (!ref_rise) [*8] ##1 (!ref_rise && idle_count >= 16'(WINDOW_CYCLES - 1)) |=> lost) // see R11
        else $error("lost not raised after idle window");
endmodule : fob_loss_detect
`default_nettype wire

// *** src/fob_fanout_ctrl.sv ***
//
// Overview of operation
// R01: Strap low: muxed pins are enables; strap high: they are side-band pins.
// R02: Board keeps the mode strap fixed while running.
// R03: Side-band mode still honours bus enable bits and dedicated enable pins.
// R04: Enable pins are active low: 0 runs the output, 1 stops it.
// R05: Side-band data shifts in on each rising side-band clock edge.
// R06: Shift/load high allows shifting; low freezes the shift register.
// R07: Falling shift/load copies the shift register to the output control register.
// R08: Serial out pin presents the bit leaving the shift register, for chaining.
// R09: First power-good high samples the straps and starts operation.
// R10: Later power-good low enters power-down; later high leaves it.
// R11: Open-drain loss output pulls low while the reference clock is lost.
// R12: On reference loss the clock outputs are parked static.
// R13: Two tri-level address straps decode to one of nine bus addresses.
// R14: Slew rate comes from a strap or from a bus setting.
// R15: Shift register holds one enable bit per output.
// R16: Output runs only when pin or side-band bit and bus bit allow it.
//
// Added by the designer: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ns
`include "fob_defs.svh"
`default_nettype none
module fob_fanout_ctrl #(
    parameter int NUM_OUT = 8,
    parameter int CLK_MHZ = 100
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Straps
    input wire logic sideband_mode_strap,
    input wire logic [1:0] addr_strap_a,
    input wire logic [1:0] addr_strap_b,
    input wire logic slew_strap,
    // Enable and side-band pins
    input wire logic out_en_a_or_serial_in,
    input wire logic out_en_b_or_serial_clk,
    input wire logic out_en_c_or_shift_load,
    input wire logic out_en_d_n,
    input wire logic out_en_e_n,
    input wire logic out_en_f_n,
    input wire logic out_en_g_n,
    input wire logic out_en_h_n,
    output logic sideband_serial_out,
    output logic sideband_serial_out_oe,
    // Power and reference
    input wire logic power_good_or_sleep_n,
    input wire logic ref_clock_in,
    output logic input_lost_n_out,
    output logic input_lost_n_oe,
    // Datapath control
    output logic [NUM_OUT-1:0] clock_out_run,
    output logic clock_out_park,
    output logic slew_fast,
    output logic [3:0] bus_address,
    output logic irq
);
    localparam int LOSS_CYCLES = (`FOB_LOSS_WINDOW_NS * CLK_MHZ) / 1000;
    localparam int NPIN = 16;

    function automatic logic [3:0] fob_addr_decode(input logic [1:0] a, input logic [1:0] b);
        logic [3:0] ia;
        logic [3:0] ib;
        ia = (a == fob_pkg::FOB_TRI_HIGH) ? 4'h2 : (a == fob_pkg::FOB_TRI_MID) ? 4'h1 : 4'h0;
        ib = (b == fob_pkg::FOB_TRI_HIGH) ? 4'h2 : (b == fob_pkg::FOB_TRI_MID) ? 4'h1 : 4'h0;
        return 4'((ib * 4'h3) + ia);
    endfunction : fob_addr_decode

    // Pin synchronisers
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] pin_st;
    logic [NPIN-1:0] pin_rise;
    logic [NPIN-1:0] pin_fall;
    assign pin_raw = {addr_strap_b, addr_strap_a, ref_clock_in, power_good_or_sleep_n, out_en_g_n, out_en_e_n,
                      out_en_c_or_shift_load, out_en_b_or_serial_clk, out_en_a_or_serial_in, out_en_d_n,
                      out_en_f_n, out_en_h_n, sideband_mode_strap, slew_strap};

    fob_sync #(.WIDTH(NPIN)) u_sync (
        .clk(clk),
        .reset_n(reset_n),
        .async_in(pin_raw),
        .stable(pin_st),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    logic lost;
    fob_loss_detect #(.WINDOW_CYCLES(LOSS_CYCLES)) u_loss (
        .clk(clk),
        .reset_n(reset_n),
        .ref_rise(pin_rise[11]),
        .lost(lost)
    );

    // Power sequencing
    fob_pkg::fob_power_e power_state;
    logic sb_mode;
    logic slew_strap_lat;
    logic [3:0] addr_lat;
    logic started;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            power_state <= fob_pkg::FOB_WAIT_GOOD;
        end else begin
            case (power_state)
                fob_pkg::FOB_WAIT_GOOD: if (pin_st[10]) power_state <= fob_pkg::FOB_RUN; // see R09
                fob_pkg::FOB_RUN: if (!pin_st[10]) power_state <= fob_pkg::FOB_SLEEP; // see R10
                fob_pkg::FOB_SLEEP: if (pin_st[10]) power_state <= fob_pkg::FOB_RUN; // see R10
                default: power_state <= fob_pkg::FOB_WAIT_GOOD;
            endcase
        end
    end
    assign started = (power_state != fob_pkg::FOB_WAIT_GOOD);

    // Straps captured once at first power-good
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sb_mode <= 1'b0;
            slew_strap_lat <= 1'b0;
            addr_lat <= 4'h0;
        end else if (power_state == fob_pkg::FOB_WAIT_GOOD && pin_st[10]) begin
            sb_mode <= pin_st[1]; // see R01, R09
            slew_strap_lat <= pin_st[0];
            addr_lat <= fob_addr_decode(pin_st[13:12], pin_st[15:14]); // see R13
        end
    end

    // Side-band shift and load
    logic [NUM_OUT-1:0] shift_reg;
    logic [NUM_OUT-1:0] sb_ctrl;
    logic sb_load;
    assign sb_load = sb_mode && started && pin_fall[7];

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            shift_reg <= '1;
        end else if (sb_mode && started && pin_st[7] && pin_rise[6]) begin
            shift_reg <= {shift_reg[NUM_OUT-2:0], pin_st[5]}; // see R05, R06, R15
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sb_ctrl <= '1;
        end else if (sb_load) begin
            sb_ctrl <= shift_reg; // see R07
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sideband_serial_out <= 1'b0;
            sideband_serial_out_oe <= 1'b0;
        end else begin
            sideband_serial_out <= shift_reg[NUM_OUT-1]; // see R08
            sideband_serial_out_oe <= sb_mode && started;
        end
    end

    // Bus registers
    logic [31:0] ctrl;
    logic [`FOB_IRQ_BITS-1:0] irq_status;
    logic [`FOB_IRQ_BITS-1:0] irq_mask;
    logic wr_pend;
    logic [11:0] wr_addr;
    logic [`FOB_IRQ_BITS-1:0] irq_event;
    logic lost_d;
    logic [NUM_OUT-1:0] pin_en;
    logic [NUM_OUT-1:0] next_run;
    logic [31:0] status_word;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            wr_pend <= 1'b0;
            wr_addr <= 12'h000;
        end else begin
            wr_pend <= hsel && hready && htrans[1] && hwrite;
            wr_addr <= haddr;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ctrl <= `FOB_CTRL_RESET;
        end else if (wr_pend && wr_addr == `FOB_REG_CTRL) begin
            ctrl <= hwdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            irq_mask <= '0;
        end else if (wr_pend && wr_addr == `FOB_REG_IRQ_MASK) begin
            irq_mask <= hwdata[`FOB_IRQ_BITS-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            lost_d <= 1'b1;
        end else begin
            lost_d <= lost;
        end
    end

    assign irq_event[`FOB_IRQ_LOST] = lost && !lost_d;
    assign irq_event[`FOB_IRQ_FOUND] = !lost && lost_d;
    assign irq_event[`FOB_IRQ_LOAD] = sb_load;
    assign irq_event[`FOB_IRQ_SLEEP] = power_state == fob_pkg::FOB_RUN && !pin_st[10];

    // Set wins over write-one-to-clear
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            irq_status <= '0;
        end else if (wr_pend && wr_addr == `FOB_REG_IRQ_STATUS) begin
            irq_status <= (irq_status & ~hwdata[`FOB_IRQ_BITS-1:0]) | irq_event;
        end else begin
            irq_status <= irq_status | irq_event;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status & irq_mask);
        end
    end

    // Output enables
    always_comb begin
        pin_en = '0;
        pin_en[0] = !pin_st[5] || sb_mode; // see R04
        pin_en[1] = !pin_st[6] || sb_mode;
        pin_en[2] = !pin_st[4];
        pin_en[3] = !pin_st[8];
        pin_en[4] = !pin_st[7] || sb_mode;
        pin_en[5] = !pin_st[3];
        pin_en[6] = !pin_st[9];
        pin_en[7] = !pin_st[2];
        if (sb_mode) begin
            // Muxed pins replaced by side-band bits, dedicated pins kept
            next_run = pin_en & ~sb_ctrl & ctrl[NUM_OUT-1:0]; // see R01, R03, R16
        end else begin
            next_run = pin_en & ctrl[NUM_OUT-1:0]; // see R16
        end
        if (!(power_state == fob_pkg::FOB_RUN) || lost) begin
            next_run = '0; // see R12
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            clock_out_run <= '0;
            clock_out_park <= 1'b1;
            input_lost_n_out <= 1'b0;
            input_lost_n_oe <= 1'b0;
            slew_fast <= 1'b0;
            bus_address <= 4'h0;
        end else begin
            clock_out_run <= next_run;
            clock_out_park <= lost; // see R12
            input_lost_n_out <= 1'b0;
            input_lost_n_oe <= lost; // see R11
            slew_fast <= ctrl[`FOB_CTRL_SLEW_SW] ? ctrl[`FOB_CTRL_SLEW_SEL] : slew_strap_lat; // see R14
            bus_address <= addr_lat;
        end
    end

    assign status_word = {12'h000, addr_lat, 3'h0, slew_fast, lost, power_state == fob_pkg::FOB_SLEEP,
                          started, sb_mode, clock_out_run};

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            hrdata <= 32'h00000000;
        end else if (hsel && hready && htrans[1] && !hwrite) begin
            case (haddr)
                `FOB_REG_CTRL: hrdata <= ctrl;
                `FOB_REG_STATUS: hrdata <= status_word;
                `FOB_REG_IRQ_STATUS: hrdata <= {28'h0000000, irq_status};
                `FOB_REG_IRQ_MASK: hrdata <= {28'h0000000, irq_mask};
                `FOB_REG_SB_CTRL: hrdata <= {24'h000000, sb_ctrl};
                default: hrdata <= 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    a_park_on_loss: assert property (@(posedge clk) disable iff (!reset_n)
        lost |=> (clock_out_run == '0) && clock_out_park) // see R12
        else $error("outputs not parked on loss");
    a_lost_pin_low: assert property (@(posedge clk) disable iff (!reset_n)
        lost |=> input_lost_n_oe && !input_lost_n_out) // see R11
        else $error("loss pin not driven low");
    a_load_copies: assert property (@(posedge clk) disable iff (!reset_n)
        sb_load |=> sb_ctrl == $past(shift_reg)) // see R07
        else $error("load did not copy shift register");
    a_shift_hold: assert property (@(posedge clk) disable iff (!reset_n)
        !pin_st[7] |=> shift_reg == $past(shift_reg)) // see R06
        else $error("shift register moved while load low");
    a_sleep_off: assert property (@(posedge clk) disable iff (!reset_n)
        power_state == fob_pkg::FOB_SLEEP |=> clock_out_run == '0) // see R10
        else $error("outputs run in power-down");
    a_serial_out: assert property (@(posedge clk) disable iff (!reset_n)
        1'b1 |=> sideband_serial_out == $past(shift_reg[NUM_OUT-1])) // see R08
        else $error("serial out wrong");
    a_bus_gate: assert property (@(posedge clk) disable iff (!reset_n)
        (ctrl[0] == 1'b0) |=> !clock_out_run[0]) // see R16
        else $error("bus enable bit ignored");
    a_pin_mode: assert property (@(posedge clk) disable iff (!reset_n)
        (!sb_mode && pin_st[8]) |=> !clock_out_run[3]) // see R04
        else $error("high enable pin did not stop output");

    c_sb_load: cover property (@(posedge clk) sb_load);
    c_sleep: cover property (@(posedge clk) power_state == fob_pkg::FOB_SLEEP);
    c_loss: cover property (@(posedge clk) irq_event[`FOB_IRQ_LOST]);
    c_irq: cover property (@(posedge clk) irq);
endmodule : fob_fanout_ctrl
`default_nettype wire

// *** sim/fob_board_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module fob_board_model (
    // Clock
    input wire logic clk,
    // Muxed enable and side-band pins
    output logic out_en_a_or_serial_in,
    output logic out_en_b_or_serial_clk,
    output logic out_en_c_or_shift_load,
    // Dedicated enable pins
    output logic out_en_d_n,
    output logic out_en_e_n,
    output logic out_en_f_n,
    output logic out_en_g_n,
    output logic out_en_h_n
);
    initial begin
        set_enables(8'hFF);
    end

    // Bit i of en_n stops output i
    task automatic set_enables(input logic [7:0] en_n);
        out_en_a_or_serial_in <= en_n[0];
        out_en_b_or_serial_clk <= en_n[1];
        out_en_d_n <= en_n[2];
        out_en_e_n <= en_n[3];
        out_en_c_or_shift_load <= en_n[4];
        out_en_f_n <= en_n[5];
        out_en_g_n <= en_n[6];
        out_en_h_n <= en_n[7];
    endtask : set_enables

    // Frame of n bits, first bit ends up in bit n-1; clock still outside frames
    task automatic shift(input logic [7:0] v, input int n, input logic ld);
        #3;
        out_en_c_or_shift_load = ld;
        #80;
        for (int i = 0; i < n; i++) begin
            out_en_a_or_serial_in = v[7 - i];
            #80;
            out_en_b_or_serial_clk = 1'b1;
            #80;
            out_en_b_or_serial_clk = 1'b0;
        end
        #80;
        out_en_a_or_serial_in = ~out_en_a_or_serial_in;
        out_en_c_or_shift_load = 1'b0;
        #80;
        @(posedge clk);
    endtask : shift
endmodule : fob_board_model
`default_nettype wire

// *** sim/test_fob_fanout_ctrl.sv ***
`timescale 1ns/1ns
`include "fob_defs.svh"
`default_nettype none
module test_fob_fanout_ctrl;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic hsel = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic sideband_mode_strap = 1'b0;
    logic [1:0] addr_strap_a = 2'h0;
    logic [1:0] addr_strap_b = 2'h0;
    logic slew_strap = 1'b1;
    logic power_good_or_sleep_n = 1'b0;
    logic ref_clock_in = 1'b0;
    logic ref_on = 1'b1;
    logic [31:0] rd;
    int n_mismatch = 0;
    int samples_checked = 0;
    wire [31:0] hrdata;
    wire hreadyout, hresp, sideband_serial_out, sideband_serial_out_oe;
    wire input_lost_n_out, input_lost_n_oe, clock_out_park, slew_fast, irq;
    wire [7:0] clock_out_run;
    wire [3:0] bus_address;
    wire out_en_a_or_serial_in, out_en_b_or_serial_clk, out_en_c_or_shift_load;
    wire out_en_d_n, out_en_e_n, out_en_f_n, out_en_g_n, out_en_h_n;
    // Open-drain pin with pull-up
    wire lost_pin = input_lost_n_oe ? input_lost_n_out : 1'b1;

    always #5 clk = ~clk;
    always #13 if (ref_on) ref_clock_in = ~ref_clock_in;

    fob_fanout_ctrl uut (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .sideband_mode_strap(sideband_mode_strap),
        .addr_strap_a(addr_strap_a), .addr_strap_b(addr_strap_b), .slew_strap(slew_strap),
        .out_en_a_or_serial_in(out_en_a_or_serial_in), .out_en_b_or_serial_clk(out_en_b_or_serial_clk),
        .out_en_c_or_shift_load(out_en_c_or_shift_load), .out_en_d_n(out_en_d_n), .out_en_e_n(out_en_e_n),
        .out_en_f_n(out_en_f_n), .out_en_g_n(out_en_g_n), .out_en_h_n(out_en_h_n),
        .sideband_serial_out(sideband_serial_out), .sideband_serial_out_oe(sideband_serial_out_oe),
        .power_good_or_sleep_n(power_good_or_sleep_n), .ref_clock_in(ref_clock_in),
        .input_lost_n_out(input_lost_n_out), .input_lost_n_oe(input_lost_n_oe),
        .clock_out_run(clock_out_run), .clock_out_park(clock_out_park), .slew_fast(slew_fast),
        .bus_address(bus_address), .irq(irq));

    fob_board_model board (.clk(clk), .out_en_a_or_serial_in(out_en_a_or_serial_in),
        .out_en_b_or_serial_clk(out_en_b_or_serial_clk), .out_en_c_or_shift_load(out_en_c_or_shift_load),
        .out_en_d_n(out_en_d_n), .out_en_e_n(out_en_e_n), .out_en_f_n(out_en_f_n),
        .out_en_g_n(out_en_g_n), .out_en_h_n(out_en_h_n));

    task automatic give_verdict;
        $display("Checks %0d, mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : give_verdict

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic check_bit(input logic got, input logic exp);
        check({31'h0, got}, {31'h0, exp});
    endtask : check_bit

    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
    endtask : cycles

    // Next edge with hready high, bounded
    task automatic wait_ready;
        int i;
        i = 0;
        @(posedge clk);
        while (hreadyout !== 1'b1) begin
            i++;
            if (i > 50) begin
                n_mismatch++;
                give_verdict();
            end
            @(posedge clk);
        end
    endtask : wait_ready

    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        hsize <= 3'b010;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_ready();
        rd = hrdata;
    endtask : bus

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(rd, exp);
    endtask : rdchk

    task automatic wait_run(input logic [7:0] exp);
        repeat (60) begin
            @(negedge clk);
            if (clock_out_run === exp) break;
        end
        check({24'h0, clock_out_run}, {24'h0, exp});
        if (clock_out_run !== exp) give_verdict();
        @(posedge clk);
    endtask : wait_run

    task automatic wait_lost(input logic exp);
        repeat (300) begin
            @(negedge clk);
            if (input_lost_n_oe === exp) break;
        end
        check_bit(input_lost_n_oe, exp);
        if (input_lost_n_oe !== exp) give_verdict();
        cycles(3);
    endtask : wait_lost

    // Straps change only while held in reset
    task automatic start(input logic sb, input logic [1:0] a, input logic [1:0] b);
        reset_n <= 1'b0;
        power_good_or_sleep_n <= 1'b0;
        sideband_mode_strap <= sb;
        addr_strap_a <= a;
        addr_strap_b <= b;
        cycles(8);
        reset_n <= 1'b1;
        cycles(4);
        power_good_or_sleep_n <= 1'b1;
        cycles(12);
    endtask : start

    initial begin
        for (int k = 0; k < 9; k++) begin
            start(1'b0, 2'(k % 3), 2'(k / 3));
            check({28'h0, bus_address}, 32'(k));
        end
        rdchk(`FOB_REG_CTRL, `FOB_CTRL_RESET);
        rdchk(`FOB_REG_IRQ_MASK, 32'h0);
        check_bit(slew_fast, 1'b1);
        wr(`FOB_REG_CTRL, 32'h000002FF);
        cycles(2);
        check_bit(slew_fast, 1'b0);
        wr(`FOB_REG_CTRL, 32'h000000FF);
        check_bit(sideband_serial_out_oe, 1'b0);
        board.set_enables(8'hA5);
        wait_run(8'h5A);
        wr(`FOB_REG_CTRL, 32'h0000000F);
        wait_run(8'h0A);
        wr(`FOB_REG_CTRL, 32'h000000FF);
        wr(`FOB_REG_IRQ_STATUS, 32'h0000000F);
        wr(`FOB_REG_IRQ_MASK, 32'h00000001);
        ref_on <= 1'b0;
        wait_lost(1'b1);
        check_bit(lost_pin, 1'b0);
        check_bit(clock_out_park, 1'b1);
        check({24'h0, clock_out_run}, 32'h0);
        check_bit(irq, 1'b1);
        rdchk(`FOB_REG_IRQ_STATUS, 32'h00000001);
        wr(`FOB_REG_IRQ_STATUS, 32'h00000001);
        rdchk(`FOB_REG_IRQ_STATUS, 32'h0);
        check_bit(irq, 1'b0);
        ref_on <= 1'b1;
        wait_lost(1'b0);
        check_bit(lost_pin, 1'b1);
        check_bit(clock_out_park, 1'b0);
        rdchk(`FOB_REG_IRQ_STATUS, 32'h00000002);
        check_bit(irq, 1'b0);
        wait_run(8'h5A);
        wr(`FOB_REG_IRQ_STATUS, 32'h0000000F);
        wr(`FOB_REG_IRQ_MASK, 32'h00000008);
        power_good_or_sleep_n <= 1'b0;
        wait_run(8'h00);
        check_bit(irq, 1'b1);
        rdchk(`FOB_REG_STATUS, 32'h00081600);
        rdchk(`FOB_REG_IRQ_STATUS, 32'h00000008);
        power_good_or_sleep_n <= 1'b1;
        wait_run(8'h5A);
        rdchk(`FOB_REG_STATUS, 32'h0008125A);
        check_bit(hresp, 1'b0);
        board.set_enables(8'h00);
        start(1'b1, 2'h0, 2'h0);
        check_bit(sideband_serial_out_oe, 1'b1);
        wr(`FOB_REG_IRQ_STATUS, 32'h0000000F);
        wr(`FOB_REG_IRQ_MASK, 32'h00000004);
        board.shift(8'hB4, 8, 1'b1);
        rdchk(`FOB_REG_SB_CTRL, 32'h000000B4);
        check_bit(sideband_serial_out, 1'b1);
        check_bit(irq, 1'b1);
        wait_run(8'h4B);
        board.set_enables(8'h08);
        wait_run(8'h43);
        board.shift(8'hFF, 8, 1'b0);
        board.shift(8'h00, 0, 1'b1);
        rdchk(`FOB_REG_SB_CTRL, 32'h000000B4);
        give_verdict();
    end
endmodule : test_fob_fanout_ctrl
`default_nettype wire
